// [logic/lsw_consts.svh]
// constants for the led shift latch watchdog block
`ifndef LSW_CONSTS_SVH
`define LSW_CONSTS_SVH

// register word offsets, byte addresses
`define LSW_ADDR_STATUS  4'h0
`define LSW_ADDR_MASK    4'h4
`define LSW_ADDR_STATE   4'h8

// event bit positions in status and mask
`define LSW_EV_WDOG      0
`define LSW_EV_FAULT     1
`define LSW_EV_OTEMP     2
`define LSW_EV_W         3

// state register field positions
`define LSW_ST_SHIFT_LSB 0
`define LSW_ST_LATCH_LSB 8
`define LSW_ST_OTEMP     16
`define LSW_ST_EXPIRED   17
`define LSW_ST_FAULT     18

// fault flag positions inside the shift register
`define LSW_FLAG_A       6
`define LSW_FLAG_B       5

// reset values
`define LSW_RST_BYTE     8'h00
`define LSW_RST_EV       3'h0
`define LSW_RST_WORD     32'h0000_0000

// timing: watchdog interval and block clock rate
`define LSW_WDOG_TIMEOUT_MS 1000
`define LSW_CLK_KHZ         250000
`define LSW_WDOG_CYCLES     (`LSW_WDOG_TIMEOUT_MS * `LSW_CLK_KHZ)

`endif

// [logic/lsw_pkg.sv]
// types for the led shift latch watchdog block
package lsw_pkg;

  // watchdog states, one-hot
  typedef enum logic [1:0]
  {
    LSW_WD_WATCH   = 2'b01,
    LSW_WD_EXPIRED = 2'b10
  } lsw_wd_state_type;

  typedef logic [7:0] lsw_byte_type;

endpackage

// [logic/lsw_sync.sv]
// two flip-flop synchroniser for a group of outside levels
`timescale 1ns/100ps
module lsw_sync
#(
  parameter int W = 1
)
(
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_ce,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_q;

  // first stage is read only by the second
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      meta_q <= '0;
      o_sync <= '0;
    end
    else if (i_ce)
    begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule

// [logic/lsw_top.sv]
// led shift register, output latch, watchdog and open-led fault reporting
//
// Contract
// - shifting and latching ignore the output gate; gate only drives sinks.
// - serial output follows shift data; each bit exits eight clocks after entry.
// - no edge on clock, data or load for 1 s clears the latch.
// - watchdog timeout clears only the latch, never the shift register.
// - leds stay off until new latch data; activity restarts the watchdog.
// - open fault is a commanded output carrying under half its current.
// - open faults are checked just after the latch load rising edge.
// - any fault sets shift bits 6 and 5 high, else both low.
// - fault loading leaves the other six shift bits unchanged.
// - after load, bit 7 shows; next clocks give bits 6, 5, then 4..0.
// - overtemperature forces outputs off, keeps registers, hysteresis 165/140 C.
// - data enters msb first, bit 7 on first clock, bit 0 on eighth.
// - latch follows shift register while load high, holds from falling edge.
// - gate high turns all sinks off without touching the latch.
// - reset clears registers, sinks off and serial output low.
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`include "lsw_consts.svh"
module lsw_top
  import lsw_pkg::*;
#(
  parameter int WDOG_CYCLES = `LSW_WDOG_CYCLES
)
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  input  wire logic        i_serial_clk,
  input  wire logic        i_serial_data,
  input  wire logic        i_latch_load,
  input  wire logic        i_gate_n,
  input  wire logic [7:0]  i_open_fault,
  input  wire logic        i_temp_above_hi,
  input  wire logic        i_temp_below_lo,
  input  wire logic [3:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [31:0]      o_rdata,
  output logic             o_serial_out,
  output logic [7:0]       o_led_sinks,
  output logic             o_irq
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------

  logic [13:0] sync_w;
  logic        sclk_s;
  logic        sdata_s;
  logic        load_s;
  logic        gate_n_s;
  logic [7:0]  open_s;
  logic        hot_s;
  logic        cool_s;

  lsw_sync #(.W(14)) u_sync
  (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_ce    (i_ce),
    .i_async ({i_serial_clk, i_serial_data, i_latch_load, i_gate_n,
               i_open_fault, i_temp_above_hi, i_temp_below_lo}),
    .o_sync  (sync_w)
  );

  // named slices of the synchronised group; one capture for every pin
  // keeps related levels, like the two thresholds, aligned in time
  assign sclk_s   = sync_w[13];
  assign sdata_s  = sync_w[12];
  assign load_s   = sync_w[11];
  assign gate_n_s = sync_w[10];
  assign open_s   = sync_w[9:2];
  assign hot_s    = sync_w[1];
  assign cool_s   = sync_w[0];

  // ----------------------------------------------------------------
  // edge detection on the monitored inputs
  // ----------------------------------------------------------------

  logic sclk_prev_q;
  logic sdata_prev_q;
  logic load_prev_q;
  logic clk_rise;
  logic load_rise;
  logic any_edge;

  // previous levels, taken from the second stage only
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      sclk_prev_q  <= 1'b0;
      sdata_prev_q <= 1'b0;
      load_prev_q  <= 1'b0;
    end
    else if (i_ce)
    begin
      sclk_prev_q  <= sclk_s;
      sdata_prev_q <= sdata_s;
      load_prev_q  <= load_s;
    end
  end

  assign clk_rise  = sclk_s & ~sclk_prev_q;
  assign load_rise = load_s & ~load_prev_q;
  // any transition, either direction, counts as activity
  assign any_edge  = (sclk_s ^ sclk_prev_q) | (sdata_s ^ sdata_prev_q)
                   | (load_s ^ load_prev_q);

  // ----------------------------------------------------------------
  // shift register and fault insertion
  // ----------------------------------------------------------------

  lsw_byte_type sr_q;
  lsw_byte_type sr_d;
  lsw_byte_type sr_shift;
  logic         fault_any;
  logic         fault_last_q;

  // a commanded output that lacks current is open; the gate plays no part
  assign fault_any = |(sr_shift & open_s);
  // msb first: new bit enters at 0 and walks up to bit 7
  assign sr_shift  = clk_rise ? {sr_q[6:0], sdata_s} : sr_q;

  // fault flags overwrite bits 6 and 5 only, after any shift
  always_comb
  begin
    sr_d = sr_shift;
    if (load_rise)
    begin
      sr_d[`LSW_FLAG_A] = fault_any;
      sr_d[`LSW_FLAG_B] = fault_any;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      sr_q         <= `LSW_RST_BYTE;
      fault_last_q <= 1'b0;
    end
    else if (i_ce)
    begin
      sr_q <= sr_d;
      if (load_rise)
        fault_last_q <= fault_any;
    end
  end

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------

  lsw_wd_state_type wd_state_q;
  lsw_wd_state_type wd_state_d;
  logic [27:0]      wd_cnt_q;
  logic             wd_fire;
  logic             wd_at_end;

  assign wd_at_end = (wd_cnt_q == 28'(WDOG_CYCLES - 1));
  assign wd_fire   = (wd_state_q == LSW_WD_WATCH) & wd_at_end & ~any_edge;

  // expired state only waits for activity; no lock-up
  always_comb
  begin
    case (wd_state_q)
      LSW_WD_WATCH:   wd_state_d = wd_fire ? LSW_WD_EXPIRED : LSW_WD_WATCH;
      LSW_WD_EXPIRED: wd_state_d = any_edge ? LSW_WD_WATCH : LSW_WD_EXPIRED;
      default:        wd_state_d = LSW_WD_WATCH;
    endcase
  end

  // counter restarts on any monitored edge
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      wd_state_q <= LSW_WD_WATCH;
      wd_cnt_q   <= 28'h0000000;
    end
    else if (i_ce)
    begin
      wd_state_q <= wd_state_d;
      if (any_edge)
        wd_cnt_q <= 28'h0000000;
      else if (!wd_at_end)
        wd_cnt_q <= wd_cnt_q + 28'h0000001;
    end
  end

  // ----------------------------------------------------------------
  // output latch and sinks
  // ----------------------------------------------------------------

  lsw_byte_type latch_q;
  lsw_byte_type latch_d;
  logic         latch_upd;
  logic         ot_q;
  logic         ot_d;

  // transparent while load high; fault insertion itself is not an update,
  // so the load edge keeps led data bits 6 and 5; clocks while load stays high shift the flags into bits 7 and 6
  assign latch_upd = load_rise | (load_s & clk_rise);
  assign latch_d   = wd_fire   ? `LSW_RST_BYTE
                   : latch_upd ? sr_shift
                   : latch_q;

  // overtemperature hysteresis, register contents untouched;
  // hot wins if both thresholds read true, which only a faulty sensor shows
  assign ot_d = hot_s ? 1'b1 : (cool_s ? 1'b0 : ot_q);

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      latch_q      <= `LSW_RST_BYTE;
      ot_q         <= 1'b0;
      o_led_sinks  <= `LSW_RST_BYTE;
      o_serial_out <= 1'b0;
    end
    else if (i_ce)
    begin
      latch_q      <= latch_d;
      ot_q         <= ot_d;
      o_led_sinks  <= (gate_n_s | ot_d) ? 8'h00 : latch_d;
      o_serial_out <= sr_d[7];
    end
  end

  // ----------------------------------------------------------------
  // register port and interrupt
  // ----------------------------------------------------------------

  logic [2:0]  st_q;
  logic [2:0]  st_d;
  logic [2:0]  mask_q;
  logic [2:0]  ev;
  logic [2:0]  st_clr;
  logic        wr_status;
  logic        wr_mask;
  logic [31:0] rd_mux;

  assign ev = {ot_d & ~ot_q, load_rise & fault_any, wd_fire};
  assign wr_status = i_wr & (i_addr == `LSW_ADDR_STATUS);
  assign wr_mask   = i_wr & (i_addr == `LSW_ADDR_MASK);
  assign st_clr    = wr_status ? i_wdata[2:0] : 3'h0;
  // a new event beats a clear in the same cycle
  assign st_d      = (st_q & ~st_clr) | ev;

  assign rd_mux = (i_addr == `LSW_ADDR_STATUS) ? {29'h0, st_q}
                : (i_addr == `LSW_ADDR_MASK)   ? {29'h0, mask_q}
                : (i_addr == `LSW_ADDR_STATE)  ? {13'h0, fault_last_q,
                    (wd_state_q == LSW_WD_EXPIRED), ot_q, latch_q, sr_q}
                : `LSW_RST_WORD;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      st_q    <= `LSW_RST_EV;
      mask_q  <= `LSW_RST_EV;
      o_irq   <= 1'b0;
      o_rdata <= `LSW_RST_WORD;
    end
    else if (i_ce)
    begin
      st_q    <= st_d;
      if (wr_mask)
        mask_q <= i_wdata[2:0];
      o_irq   <= |(st_d & (wr_mask ? i_wdata[2:0] : mask_q));
      o_rdata <= i_rd ? rd_mux : `LSW_RST_WORD;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  reset_outs_a: assert property (disable iff (1'b0)
    i_rst |=> (o_led_sinks == 8'h00) && !o_serial_out && (latch_q == 8'h00))
    else $error("outputs not cleared by reset");
  ser_out_a: assert property (i_ce && clk_rise && !load_rise |=>
    o_serial_out == $past(sr_q[6]))
    else $error("serial output not shifted bit");
  shift_in_a: assert property (i_ce && clk_rise |=> sr_q[0] == $past(sdata_s))
    else $error("serial bit not taken into bit 0");
  fault_bits_a: assert property (i_ce && load_rise |=>
    sr_q[6] == $past(fault_any) && sr_q[5] == $past(fault_any))
    else $error("fault flags wrong");
  keep_bits_a: assert property (i_ce && load_rise && !clk_rise |=>
    sr_q[7] == $past(sr_q[7]) && sr_q[4:0] == $past(sr_q[4:0]))
    else $error("fault load disturbed data bits");
  wdog_clear_a: assert property (i_ce && wd_fire |=>
    latch_q == 8'h00 && o_led_sinks == 8'h00)
    else $error("watchdog did not clear latch");
  wdog_keep_a: assert property (i_ce && wd_fire |=> sr_q == $past(sr_q))
    else $error("watchdog touched shift register");
  wdog_restart_a: assert property (i_ce && any_edge |=>
    wd_cnt_q == 28'h0000000 && wd_state_q == LSW_WD_WATCH)
    else $error("activity did not restart watchdog");
  latch_hold_a: assert property (i_ce && !load_s && !wd_fire |=>
    $stable(latch_q))
    else $error("latch changed while load low");
  gate_off_a: assert property (i_ce && gate_n_s |=> o_led_sinks == 8'h00)
    else $error("sinks driven with gate high");
  otemp_a: assert property (i_ce && ot_d |=> o_led_sinks == 8'h00
    && ($stable(sr_q) || $past(clk_rise) || $past(load_rise)))
    else $error("sinks on while overheated");
  // latch, sinks, overtemperature hold and watchdog blanking
  led_follow_a: assert property (i_ce && !gate_n_s && !ot_d |=>
    o_led_sinks == latch_q)
    else $error("sinks do not follow latch");
  otemp_hold_a: assert property (i_ce && ot_q && !cool_s |=>
    ot_q)
    else $error("overtemperature released before cool");
  latch_follow_a: assert property (i_ce && load_s && clk_rise && !load_rise |=>
    latch_q == sr_q)
    else $error("latch not transparent while load high");
  load_copy_a: assert property (i_ce && load_rise |=>
    latch_q == $past(sr_shift))
    else $error("latch missed data at load");
  dark_expired_a: assert property (i_ce && wd_state_q == LSW_WD_EXPIRED |->
    latch_q == 8'h00 && o_led_sinks == 8'h00)
    else $error("leds lit after watchdog timeout");

  // main scenarios worth seeing at least once
  wd_fire_c:   cover property (i_ce && wd_fire);
  fault_c:     cover property (i_ce && load_rise && fault_any);
  otemp_c:     cover property (i_ce && ot_d && !ot_q);
  irq_c:       cover property (o_irq);
  gate_load_c: cover property (i_ce && load_rise && gate_n_s);

endmodule

// [bench/lsw_host.sv]
// host controller model driving the serial link and latch load
`timescale 1ns/100ps
module lsw_host
(
  input  wire logic i_clk,
  input  wire logic i_serial_out,
  output logic      o_serial_clk,
  output logic      o_serial_data,
  output logic      o_latch_load
);
  import lsw_pkg::*;

  // ----------------------------------------
  // link idle state
  // ----------------------------------------
  initial
  begin
    o_serial_clk  = 1'b0;
    o_serial_data = 1'b0;
    o_latch_load  = 1'b0;
  end

  // half of a 160 ns link clock period
  task automatic half();
    repeat (20) @(posedge i_clk);
  endtask

  // ----------------------------------------
  // one frame; returned bits sampled just before each rise
  // ----------------------------------------
  task automatic xfer(input lsw_byte_type tx, output lsw_byte_type rx);
    for (int i = 7; i >= 0; i--)
    begin
      o_serial_data <= tx[i];
      repeat (19) @(posedge i_clk);
      #1 rx[i] = i_serial_out;
      @(posedge i_clk);
      o_serial_clk <= 1'b1;
      half();
      o_serial_clk <= 1'b0;
    end
  endtask

  // load pulse, long enough for the sampled edge detect
  task automatic load();
    o_latch_load <= 1'b1;
    half();
    o_latch_load <= 1'b0;
    half();
  endtask
endmodule

// [bench/led_shift_latch_watchdog_tb.sv]
// self-checking testbench for the led shift latch watchdog block
`timescale 1ns/100ps
`include "lsw_consts.svh"
module led_shift_latch_watchdog_tb;
  import lsw_pkg::*;

  logic        clk, rst, ce, gate_n, above, below, wr, rd;
  logic [7:0]  fault;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata, d;
  logic        sout, sclk, sdata, load, irq;
  logic [7:0]  sinks;
  lsw_byte_type rx;
  int          tests_run, miscompares, cycles;

  // ----------------------------------------
  // clock, reset and hang limit
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      final_report();
    end
  end

  lsw_top #(.WDOG_CYCLES(200)) dut_u
  (
    .i_clk(clk), .i_rst(rst), .i_ce(ce), .i_serial_clk(sclk),
    .i_serial_data(sdata), .i_latch_load(load), .i_gate_n(gate_n),
    .i_open_fault(fault), .i_temp_above_hi(above), .i_temp_below_lo(below),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .o_serial_out(sout), .o_led_sinks(sinks), .o_irq(irq)
  );

  lsw_host host_u
  (
    .i_clk(clk), .i_serial_out(sout), .o_serial_clk(sclk),
    .o_serial_data(sdata), .o_latch_load(load)
  );

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    waitc(2); // irq is registered from the next status, at the same edge as the status update
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_frames();
    check(sinks, 8'h00);
    check(sout, 1'b0);
    host_u.xfer(8'hA5, rx);
    check(rx, 8'h00);
    host_u.load();
    check(sinks, 8'hA5);
    rd_reg(`LSW_ADDR_STATE);
    check(d[15:8], 8'hA5);
    fault <= 8'h04; // lit output reads open
    host_u.xfer(8'h3C, rx);
    check(rx, 8'h85);
    host_u.load();
    check(sinks, 8'h3C);
    fault <= 8'h00;
    rd_reg(`LSW_ADDR_STATUS);
    check(d, 32'h0000_0002);
    check(irq, 1'b0);
    wr_reg(`LSW_ADDR_MASK, 32'h0000_0002);
    check(irq, 1'b1);
    wr_reg(`LSW_ADDR_STATUS, 32'h0000_0002);
    check(irq, 1'b0);
    wr_reg(`LSW_ADDR_MASK, 32'h0000_0000);
    host_u.xfer(8'h5A, rx);
    check(rx, 8'h7C);
  endtask

  // gate high during load: latch still takes data, sinks stay off
  task automatic t_gate();
    gate_n <= 1'b1;
    host_u.load();
    check(sinks, 8'h00);
    rd_reg(`LSW_ADDR_STATE);
    check(d[15:8], 8'h5A);
    check(d[7:0], 8'h1A);
    gate_n <= 1'b0;
    waitc(4);
    check(sinks, 8'h5A);
  endtask

  // kept short so the watchdog does not fire meanwhile
  task automatic t_overtemp();
    above <= 1'b1;
    waitc(4);
    above <= 1'b0;
    waitc(4);
    check(sinks, 8'h00);
    rd_reg(`LSW_ADDR_STATE);
    check(d[15:8], 8'h5A);
    below <= 1'b1;
    waitc(4);
    below <= 1'b0;
    waitc(4);
    check(sinks, 8'h5A);
  endtask

  task automatic t_watchdog();
    waitc(250);
    check(sinks, 8'h00);
    rd_reg(`LSW_ADDR_STATE);
    check(d[15:8], 8'h00);
    rd_reg(`LSW_ADDR_STATUS);
    check(d, 32'h0000_0005);
    rd_reg(4'hC);
    check(d, 32'h0000_0000);
    host_u.xfer(8'hFF, rx);
    check(rx, 8'h1A);
    host_u.load();
    check(sinks, 8'hFF);
  endtask

  // one lit output per frame for outputs 0 to 7, then a blank frame; each frame echoes the verdict on the one before
  task automatic t_locate();
    lsw_byte_type prev, pat;
    prev = 8'hFF;
    fault <= 8'h08; // only output 3 has an open led
    for (int i = 0; i < 9; i++)
    begin
      pat = 8'(9'h001 << i);
      host_u.xfer(pat, rx);
      check(rx[6], rx[5]);
      check(rx, (prev & 8'h9F) | ((prev == 8'h08) ? 8'h60 : 8'h00));
      host_u.load();
      check(sinks, pat);
      prev = pat;
    end
    fault <= 8'h00;
  endtask

  // clock enable low: link activity is lost, shift register stays put
  task automatic t_freeze();
    ce <= 1'b0;
    host_u.xfer(8'hC3, rx);
    check(rx, 8'h00);
    ce <= 1'b1;
    host_u.xfer(8'h00, rx);
    check(rx, 8'h00);
  endtask

  // ----------------------------------------
  // verdict and main sequence
  // ----------------------------------------
  task automatic final_report();
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    rst = 1'b1; ce = 1'b1; gate_n = 1'b0; above = 1'b0; below = 1'b0;
    wr = 1'b0; rd = 1'b0; fault = 8'h00; addr = 4'h0; wdata = 32'h0;
    tests_run = 0; miscompares = 0; cycles = 0;
    waitc(3);
    rst <= 1'b0;
    waitc(2);
    t_frames();
    t_gate();
    t_overtemp();
    t_watchdog();
    t_locate();
    t_freeze();
    final_report();
  end
endmodule
